// ===== logic/programmable_counter_array.sv
// What this block does
// - One 16-bit counter, five compare modules, lines
// - Timebase: div12, div4, timer0, external falls
// - Counter runs only while run bit set
// - Wrap from all ones sets overflow flag
// - Overflow requests interrupt only when enabled
// - Overflow flag stays until software clears
// - Low read latches high byte; reads harmless
// - Idle suspend bit halts counter during idle
// - Selected line edges capture the count
// - Capture sets sticky module flag, may interrupt
// - Comparator and match enabled: equality sets flag
// - Toggle mode inverts line on each match
// - PWM: set on low match, clear on wrap
// - PWM reloads low compare from high on wrap
// - Module flag interrupts only when enabled
`timescale 1ns/100ps
module programmable_counter_array
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic core_idle_in,
  input wire logic timer0_ovf_in,
  input wire logic ext_count_input_in,
  input wire logic [4:0] module_line_in,
  output logic [4:0] module_line_out,
  output logic [4:0] module_line_oe_out,
  output logic irq_out
);
  localparam int N = counter_array_pkg::NUM_MODULES;

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic counter_moved_reg;
  logic [7:0] latched_high_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;
  logic [3:0] presc_reg;
  logic [3:0] presc_next;
  logic [1:0] ext_gap_reg;
  logic [1:0] ext_gap_next;
  logic ext_prev_reg;
  logic [N:0] sync1_reg;
  logic [N:0] sync2_reg;
  logic ovf_flag_reg;
  logic run_reg;
  logic [N-1:0] event_flags_reg;
  logic idle_suspend_reg;
  logic [1:0] tb_sel_reg;
  logic ovf_irq_en_reg;
  logic irq_reg;
  logic ovf_flag_next;
  logic [N-1:0] event_flags_next;
  logic [7:0] mod_mode [N];
  logic [7:0] mod_low [N];
  logic [7:0] mod_high [N];
  logic [N-1:0] mod_event;
  logic [N-1:0] mod_irq_en;
  logic [N-1:0] mod_line;
  logic [N-1:0] mod_oe;
  // Drive enables registered so the pins never see a decode glitch
  logic [N-1:0] line_oe_reg;

  // Register decode
  wire wr_ctrl = sfr_wr_in && (sfr_addr_in == counter_array_pkg::ADDR_ARRAY_CONTROL);
  wire wr_mode = sfr_wr_in && (sfr_addr_in == counter_array_pkg::ADDR_ARRAY_MODE);
  wire rd_low = sfr_rd_in && (sfr_addr_in == counter_array_pkg::ADDR_COUNTER_LOW);
  wire [7:0] mm_idx = sfr_addr_in - counter_array_pkg::ADDR_MODULE_MODE_BASE;
  wire [7:0] lo_idx = sfr_addr_in - counter_array_pkg::ADDR_COMPARE_LOW_BASE;
  wire [7:0] hi_idx = sfr_addr_in - counter_array_pkg::ADDR_COMPARE_HIGH_BASE;

  // Synchronised inputs: the line inputs and the external count
  wire [N-1:0] line_sync = sync2_reg[N-1:0];
  wire ext_sync = sync2_reg[N];
  wire ext_fall = ext_prev_reg & ~ext_sync;
  // Hold-off keeps external counting at or below a quarter of the clock
  wire ext_tick = ext_fall && (ext_gap_reg == 2'h0);
  wire [3:0] presc_last = (tb_sel_reg == counter_array_pkg::TB_DIV12) ?
    counter_array_pkg::PRESC_DIV12_LAST : counter_array_pkg::PRESC_DIV4_LAST;
  wire presc_tick = presc_reg >= presc_last;

  logic tb_tick;
  always_comb
  begin
    unique case (tb_sel_reg)
      counter_array_pkg::TB_DIV12: tb_tick = presc_tick;
      counter_array_pkg::TB_DIV4: tb_tick = presc_tick;
      counter_array_pkg::TB_TIMER0: tb_tick = timer0_ovf_in;
      counter_array_pkg::TB_EXT: tb_tick = ext_tick;
    endcase
  end

  wire idle_hold = idle_suspend_reg & core_idle_in;
  wire advance = tb_tick & run_reg & ~idle_hold;
  wire wrap = advance && (count_reg == 16'hffff);

  assign presc_next = presc_tick ? 4'h0 : presc_reg + 4'h1;
  assign ext_gap_next = ext_tick ? counter_array_pkg::EXT_GAP_LAST :
    ((ext_gap_reg != 2'h0) ? ext_gap_reg - 2'h1 : 2'h0);
  assign count_next = advance ? count_reg + 16'h0001 : count_reg;

  // Hardware set wins over a software clear in the same cycle
  assign ovf_flag_next = wrap |
    (wr_ctrl ? sfr_wdata_in[counter_array_pkg::CTRL_OVF_BIT] : ovf_flag_reg);
  assign event_flags_next = mod_event |
    (wr_ctrl ? sfr_wdata_in[N-1:0] : event_flags_reg);

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_mod
      capture_compare_unit u_unit
      (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .counter_in(count_reg),
        .counter_moved_in(counter_moved_reg),
        .line_sync_in(line_sync[g]),
        .mode_wr_in(sfr_wr_in && (mm_idx == 8'(g))),
        .low_wr_in(sfr_wr_in && (lo_idx == 8'(g))),
        .high_wr_in(sfr_wr_in && (hi_idx == 8'(g))),
        .wdata_in(sfr_wdata_in),
        .mode_out(mod_mode[g]),
        .cmp_low_out(mod_low[g]),
        .cmp_high_out(mod_high[g]),
        .event_out(mod_event[g]),
        .line_out(mod_line[g]),
        .line_oe_out(mod_oe[g])
      );
      assign mod_irq_en[g] = mod_mode[g][counter_array_pkg::MM_IRQ_BIT];
    end
  endgenerate

  assign module_line_out = mod_line;
  assign module_line_oe_out = line_oe_reg;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (sfr_addr_in == counter_array_pkg::ADDR_ARRAY_CONTROL)
      rd_mux = {ovf_flag_reg, run_reg, 1'b0, event_flags_reg};
    else if (sfr_addr_in == counter_array_pkg::ADDR_ARRAY_MODE)
      rd_mux = {idle_suspend_reg, 4'h0, tb_sel_reg, ovf_irq_en_reg};
    else if (sfr_addr_in == counter_array_pkg::ADDR_COUNTER_LOW)
      rd_mux = count_reg[7:0];
    else if (sfr_addr_in == counter_array_pkg::ADDR_COUNTER_HIGH)
      rd_mux = latched_high_reg;
    for (int i = 0; i < N; i++)
    begin
      if (mm_idx == 8'(i))
        rd_mux = mod_mode[i];
      if (lo_idx == 8'(i))
        rd_mux = mod_low[i];
      if (hi_idx == 8'(i))
        rd_mux = mod_high[i];
    end
  end

  // Enabled overflow and module flags share one request line
  wire irq_next = (ovf_flag_reg & ovf_irq_en_reg) |
    (|(event_flags_reg & mod_irq_en));

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ext_prev_reg <= 1'b0;
      ext_gap_reg <= 2'h0;
      presc_reg <= 4'h0;
      count_reg <= 16'h0000;
      counter_moved_reg <= 1'b0;
      latched_high_reg <= 8'h00;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      line_oe_reg <= '0;
    end
    else if (clk_en_in)
    begin
      sync1_reg <= {ext_count_input_in, module_line_in};
      sync2_reg <= sync1_reg;
      ext_prev_reg <= ext_sync;
      ext_gap_reg <= ext_gap_next;
      presc_reg <= presc_next;
      count_reg <= count_next;
      counter_moved_reg <= advance;
      if (rd_low)
        latched_high_reg <= count_reg[15:8];
      if (sfr_rd_in)
        rdata_reg <= rd_mux;
      irq_reg <= irq_next;
      line_oe_reg <= mod_oe;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      ovf_flag_reg <= counter_array_pkg::CTRL_RESET[counter_array_pkg::CTRL_OVF_BIT];
      run_reg <= counter_array_pkg::CTRL_RESET[counter_array_pkg::CTRL_RUN_BIT];
      event_flags_reg <= counter_array_pkg::CTRL_RESET[N-1:0];
      idle_suspend_reg <= counter_array_pkg::MODE_RESET[counter_array_pkg::MODE_IDLE_BIT];
      tb_sel_reg <= counter_array_pkg::MODE_RESET[counter_array_pkg::MODE_TB_HI_BIT:
        counter_array_pkg::MODE_TB_LO_BIT];
      ovf_irq_en_reg <= counter_array_pkg::MODE_RESET[counter_array_pkg::MODE_OVF_IRQ_BIT];
    end
    else if (clk_en_in)
    begin
      ovf_flag_reg <= ovf_flag_next;
      event_flags_reg <= event_flags_next;
      if (wr_ctrl)
        run_reg <= sfr_wdata_in[counter_array_pkg::CTRL_RUN_BIT];
      if (wr_mode)
      begin
        idle_suspend_reg <= sfr_wdata_in[counter_array_pkg::MODE_IDLE_BIT];
        tb_sel_reg <= sfr_wdata_in[counter_array_pkg::MODE_TB_HI_BIT:
          counter_array_pkg::MODE_TB_LO_BIT];
        ovf_irq_en_reg <= sfr_wdata_in[counter_array_pkg::MODE_OVF_IRQ_BIT];
      end
    end
  end

  assign sfr_rdata_out = rdata_reg;
  assign irq_out = irq_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  ovf_set_a: assert property (clk_en_in && wrap |=> ovf_flag_reg && count_reg == 16'h0000)
    else $error("wrap did not set overflow flag");
  run_stop_a: assert property (clk_en_in && !run_reg |=> count_reg == $past(count_reg))
    else $error("counter moved while stopped");
  idle_hold_a: assert property (clk_en_in && idle_suspend_reg && core_idle_in |=>
    count_reg == $past(count_reg))
    else $error("counter advanced during suspended idle");
  high_latch_a: assert property (clk_en_in && rd_low |=>
    latched_high_reg == $past(count_reg[15:8]))
    else $error("high byte not latched on low read");
  ovf_irq_a: assert property (clk_en_in && ovf_flag_reg && ovf_irq_en_reg |=> irq_out)
    else $error("enabled overflow gave no request");
  flag_sticky_a: assert property (clk_en_in && ovf_flag_reg && !wr_ctrl |=> ovf_flag_reg)
    else $error("overflow flag cleared without software");
  div4_space_a: assert property (run_reg && clk_en_in && tb_sel_reg ==
    counter_array_pkg::TB_DIV4 && advance |=> !advance [*3])
    else $error("divide by four ticks too close");
  event_flag_a: assert property (clk_en_in && mod_event[0] |=> event_flags_reg[0])
    else $error("module event did not set its flag");
  no_irq_a: assert property (clk_en_in && !ovf_flag_reg && event_flags_reg == '0 |=> !irq_out)
    else $error("request without any flag");

  // Hold-off keeps external ticks four clocks apart at least
  ext_gap_a: assert property (clk_en_in && ext_tick |=> !ext_tick [*3])
    else $error("external ticks too close");
  count_step_a: assert property (clk_en_in && advance |=>
    count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");
  wrap_only_a: assert property (clk_en_in && !ovf_flag_reg && !wrap && !wr_ctrl
    |=> !ovf_flag_reg)
    else $error("overflow flag set without a wrap");
  ovf_clear_a: assert property (clk_en_in && wr_ctrl && !wrap &&
    !sfr_wdata_in[counter_array_pkg::CTRL_OVF_BIT] |=> !ovf_flag_reg)
    else $error("overflow flag not cleared by software");
  ovf_mask_a: assert property (clk_en_in && !ovf_irq_en_reg &&
    (event_flags_reg & mod_irq_en) == '0 |=> !irq_out)
    else $error("masked overflow gave a request");
  low_read_a: assert property (clk_en_in && rd_low |=>
    sfr_rdata_out == $past(count_reg[7:0]))
    else $error("low byte read returned wrong value");
  high_read_a: assert property (clk_en_in && sfr_rd_in &&
    sfr_addr_in == counter_array_pkg::ADDR_COUNTER_HIGH |=>
    sfr_rdata_out == $past(latched_high_reg))
    else $error("high byte read missed the latch");
  latch_hold_a: assert property (clk_en_in && !rd_low |=>
    latched_high_reg == $past(latched_high_reg))
    else $error("high byte latch moved without a low read");
  event_all_a: assert property (clk_en_in && |mod_event |=>
    (event_flags_reg & $past(mod_event)) == $past(mod_event))
    else $error("a module flag missed its event");
  flag_clear_a: assert property (clk_en_in && wr_ctrl && !sfr_wdata_in[0] &&
    !mod_event[0] |=> !event_flags_reg[0])
    else $error("module flag not cleared by software");
  mod_irq_a: assert property (clk_en_in && |(event_flags_reg & mod_irq_en) |=>
    irq_out)
    else $error("enabled module flag gave no request");
  sync_pipe_a: assert property (clk_en_in |=> sync2_reg == $past(sync1_reg))
    else $error("synchroniser stages out of step");

  wrap_cov: cover property (wrap);
  set_clear_cov: cover property (wr_ctrl && |mod_event);
  idle_cov: cover property (idle_hold && run_reg && tb_tick);
endmodule // programmable_counter_array

// ===== logic/counter_array_pkg.sv
package counter_array_pkg;
  localparam int NUM_MODULES = 5;
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_ARRAY_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_ARRAY_MODE = 8'hd9;
  localparam logic [7:0] ADDR_MODULE_MODE_BASE = 8'hda;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'he9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hf9;
  localparam logic [7:0] ADDR_COMPARE_LOW_BASE = 8'hea;
  localparam logic [7:0] ADDR_COMPARE_HIGH_BASE = 8'hfa;
  // Control register fields
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Mode register fields
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_HI_BIT = 2;
  localparam int MODE_TB_LO_BIT = 1;
  localparam int MODE_OVF_IRQ_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Module mode fields
  localparam int MM_COMP_BIT = 6;
  localparam int MM_RISE_BIT = 5;
  localparam int MM_FALL_BIT = 4;
  localparam int MM_MATCH_BIT = 3;
  localparam int MM_TOGGLE_BIT = 2;
  localparam int MM_PWM_BIT = 1;
  localparam int MM_IRQ_BIT = 0;
  localparam logic [7:0] MM_WRITE_MASK = 8'h7f;
  localparam logic [7:0] MODULE_RESET = 8'h00;
  // Timebase selections
  localparam logic [1:0] TB_DIV12 = 2'h0;
  localparam logic [1:0] TB_DIV4 = 2'h1;
  localparam logic [1:0] TB_TIMER0 = 2'h2;
  localparam logic [1:0] TB_EXT = 2'h3;
  localparam logic [3:0] PRESC_DIV12_LAST = 4'hb;
  localparam logic [3:0] PRESC_DIV4_LAST = 4'h3;
  // External count accepted at most once per four system clocks
  localparam logic [1:0] EXT_GAP_LAST = 2'h3;
endpackage

// ===== logic/capture_compare_unit.sv
`timescale 1ns/100ps
module capture_compare_unit
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [15:0] counter_in,
  input wire logic counter_moved_in,
  input wire logic line_sync_in,
  input wire logic mode_wr_in,
  input wire logic low_wr_in,
  input wire logic high_wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] mode_out,
  output logic [7:0] cmp_low_out,
  output logic [7:0] cmp_high_out,
  output logic event_out,
  output logic line_out,
  output logic line_oe_out
);
  logic [7:0] mode_reg;
  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic line_reg;
  logic prev_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;
  logic line_next;

  wire comp_en = mode_reg[counter_array_pkg::MM_COMP_BIT];
  wire rise_en = mode_reg[counter_array_pkg::MM_RISE_BIT];
  wire fall_en = mode_reg[counter_array_pkg::MM_FALL_BIT];
  wire match_en = mode_reg[counter_array_pkg::MM_MATCH_BIT];
  wire toggle_en = mode_reg[counter_array_pkg::MM_TOGGLE_BIT];
  wire pwm_en = mode_reg[counter_array_pkg::MM_PWM_BIT];
  wire rise_edge = line_sync_in & ~prev_reg;
  wire fall_edge = ~line_sync_in & prev_reg;
  wire capture = (rise_en & rise_edge) | (fall_en & fall_edge);
  // Compare only on a fresh count, so a stalled counter toggles once
  wire full_match = counter_moved_in && (counter_in == {high_reg, low_reg});
  wire match_hit = comp_en & match_en & full_match;
  wire hso_toggle = match_hit & toggle_en;
  wire pwm_mode = comp_en & pwm_en;
  wire low_wrap = counter_moved_in && (counter_in[7:0] == 8'h00);
  wire pwm_set = pwm_mode && counter_moved_in && (counter_in[7:0] == low_reg);

  assign event_out = capture | match_hit;
  assign mode_out = mode_reg;
  assign cmp_low_out = low_reg;
  assign cmp_high_out = high_reg;
  assign line_out = line_reg;
  assign line_oe_out = pwm_mode | (comp_en & match_en & toggle_en);

  always_comb
  begin
    low_next = low_reg;
    high_next = high_reg;
    if (capture)
    begin
      low_next = counter_in[7:0];
      high_next = counter_in[15:8];
    end
    else
    begin
      if (low_wr_in)
        low_next = wdata_in;
      else if (pwm_mode && low_wrap)
        low_next = high_reg;
      if (high_wr_in)
        high_next = wdata_in;
    end
  end

  // Match wins over wrap so a compare byte of zero gives a steady high
  always_comb
  begin
    line_next = line_reg;
    if (pwm_mode)
    begin
      if (pwm_set)
        line_next = 1'b1;
      else if (low_wrap)
        line_next = 1'b0;
    end
    else if (hso_toggle)
      line_next = ~line_reg;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_reg <= counter_array_pkg::MODULE_RESET;
      low_reg <= 8'h00;
      high_reg <= 8'h00;
      line_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (mode_wr_in)
        mode_reg <= wdata_in & counter_array_pkg::MM_WRITE_MASK;
      low_reg <= low_next;
      high_reg <= high_next;
      line_reg <= line_next;
      prev_reg <= line_sync_in;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  capture_load_a: assert property (clk_en_in && capture |=>
    {cmp_high_out, cmp_low_out} == $past(counter_in))
    else $error("capture did not load the count");
  hso_toggle_a: assert property (clk_en_in && hso_toggle && !pwm_mode |=>
    line_out != $past(line_out))
    else $error("output line did not toggle on match");
  pwm_reload_a: assert property (clk_en_in && pwm_mode && low_wrap && !capture
    && !low_wr_in |=> cmp_low_out == $past(cmp_high_out))
    else $error("compare low byte not reloaded on wrap");
  pwm_high_a: assert property (clk_en_in && pwm_set |=> line_out)
    else $error("pwm line not set on low byte match");
  pwm_cov: cover property (pwm_mode && pwm_set ##[1:300] pwm_mode && low_wrap);
  capture_cov: cover property (capture && rise_en && fall_en);
endmodule // capture_compare_unit

// ===== tb/host_cpu_model.sv
`timescale 1ns/100ps
module host_cpu_model
(
  input wire logic sys_clk_in,
  input wire logic [7:0] sfr_rdata_in,
  output logic [7:0] sfr_addr_out,
  output logic [7:0] sfr_wdata_out,
  output logic sfr_wr_out,
  output logic sfr_rd_out
);
  initial
  begin
    sfr_addr_out = 8'h00;
    sfr_wdata_out = 8'h00;
    sfr_wr_out = 1'b0;
    sfr_rd_out = 1'b0;
  end
  // Idle bus shows inverted values so stale data never passes
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    sfr_addr_out = addr;
    sfr_wdata_out = data;
    sfr_wr_out = 1'b1;
    @(negedge sys_clk_in);
    sfr_wr_out = 1'b0;
    sfr_addr_out = ~addr;
    sfr_wdata_out = ~data;
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk_in);
    sfr_addr_out = addr;
    sfr_rd_out = 1'b1;
    @(negedge sys_clk_in);
    sfr_rd_out = 1'b0;
    sfr_addr_out = ~addr;
    data = sfr_rdata_in;
  endtask
endmodule // host_cpu_model

// ===== tb/programmable_counter_array_tb.sv
`timescale 1ns/100ps
module programmable_counter_array_tb;
  logic sys_clk_in;
  logic rst_n_in;
  logic core_idle_in;
  logic timer0_ovf_in;
  logic ext_count_input_in;
  logic [4:0] module_line_in;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  logic [4:0] module_line_out;
  logic [4:0] module_line_oe_out;
  logic irq_out;
  int miscompares;
  int n_tests;
  int ones;
  logic [7:0] rd8;
  logic [15:0] c0;
  logic [15:0] d;
  host_cpu_model i_host
  (
    .sys_clk_in(sys_clk_in),
    .sfr_rdata_in(sfr_rdata),
    .sfr_addr_out(sfr_addr),
    .sfr_wdata_out(sfr_wdata),
    .sfr_wr_out(sfr_wr),
    .sfr_rd_out(sfr_rd)
  );
  programmable_counter_array i_dut
  (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(1'b1),
    .sfr_addr_in(sfr_addr),
    .sfr_wdata_in(sfr_wdata),
    .sfr_wr_in(sfr_wr),
    .sfr_rd_in(sfr_rd),
    .sfr_rdata_out(sfr_rdata),
    .core_idle_in(core_idle_in),
    .timer0_ovf_in(timer0_ovf_in),
    .ext_count_input_in(ext_count_input_in),
    .module_line_in(module_line_in),
    .module_line_out(module_line_out),
    .module_line_oe_out(module_line_oe_out),
    .irq_out(irq_out)
  );
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_rng(input logic [15:0] got, input logic [15:0] lo,
                           input logic [15:0] hi, input string what);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %0d", $time, what, got);
    end
  endtask
  task automatic read_count(output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    i_host.read_reg(8'he9, lo);
    i_host.read_reg(8'hf9, hi);
    v = {hi, lo};
  endtask
  task automatic run_for(input logic [7:0] mode, input int n, output logic [15:0] dv);
    logic [15:0] a;
    logic [15:0] b;
    i_host.write_reg(8'hd9, mode);
    read_count(a);
    i_host.write_reg(8'hd8, 8'h40);
    repeat (n) @(negedge sys_clk_in);
    i_host.write_reg(8'hd8, 8'h00);
    read_count(b);
    dv = b - a;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    // Runs about 70k cycles; the limit leaves margin
    repeat (90000) @(posedge sys_clk_in);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    rst_n_in = 1'b0;
    core_idle_in = 1'b0;
    timer0_ovf_in = 1'b0;
    ext_count_input_in = 1'b1;
    module_line_in = 5'h00;
    repeat (10) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    i_host.read_reg(8'hd8, rd8);
    check8(rd8, 8'h00, "control reset");
    i_host.read_reg(8'hd9, rd8);
    check8(rd8, 8'h00, "mode reset");
    i_host.read_reg(8'hc0, rd8);
    check8(rd8, 8'h00, "unmapped");
    i_host.write_reg(8'hd9, 8'hff);
    i_host.read_reg(8'hd9, rd8);
    check8(rd8, 8'h87, "mode bits");
    i_host.write_reg(8'hda, 8'hff);
    i_host.read_reg(8'hda, rd8);
    check8(rd8, 8'h7f, "module mode bits");
    i_host.write_reg(8'hda, 8'h00);
    $display("test registers done");
    run_for(8'h00, 480, d);
    check_rng(d, 16'd38, 16'd42, "div12");
    run_for(8'h02, 480, d);
    check_rng(d, 16'd118, 16'd122, "div4");
    read_count(c0);
    repeat (50) @(negedge sys_clk_in);
    read_count(d);
    check_rng(d, c0, c0, "stopped");
    core_idle_in = 1'b1;
    run_for(8'h82, 400, d);
    check_rng(d, 16'd0, 16'd0, "idle suspend");
    run_for(8'h02, 400, d);
    check_rng(d, 16'd98, 16'd102, "idle run");
    core_idle_in = 1'b0;
    fork
      run_for(8'h06, 240, d);
      begin
        repeat (20) @(negedge sys_clk_in);
        repeat (20)
        begin
          ext_count_input_in = 1'b0;
          repeat (5) @(negedge sys_clk_in);
          ext_count_input_in = 1'b1;
          repeat (5) @(negedge sys_clk_in);
        end
      end
    join
    check_rng(d, 16'd20, 16'd20, "ext falls");
    $display("test timebase done");
    i_host.write_reg(8'hd9, 8'h04);
    timer0_ovf_in = 1'b1;
    i_host.write_reg(8'hd8, 8'h40);
    repeat (65600) @(negedge sys_clk_in);
    timer0_ovf_in = 1'b0;
    i_host.read_reg(8'hd8, rd8);
    check8(rd8 & 8'h80, 8'h80, "overflow flag");
    check8({7'h00, irq_out}, 8'h00, "irq masked");
    i_host.write_reg(8'hd9, 8'h05);
    repeat (3) @(negedge sys_clk_in);
    check8({7'h00, irq_out}, 8'h01, "irq overflow");
    repeat (20) @(negedge sys_clk_in);
    i_host.read_reg(8'hd8, rd8);
    check8(rd8 & 8'h80, 8'h80, "flag sticky");
    i_host.write_reg(8'hd8, 8'h00);
    repeat (3) @(negedge sys_clk_in);
    check8({7'h00, irq_out}, 8'h00, "irq cleared");
    $display("test overflow done");
    i_host.write_reg(8'hda, 8'h21);
    i_host.write_reg(8'hdb, 8'h10);
    read_count(c0);
    module_line_in = 5'h03;
    repeat (8) @(negedge sys_clk_in);
    i_host.read_reg(8'hea, rd8);
    check8(rd8, c0[7:0], "capture low");
    i_host.read_reg(8'hfa, rd8);
    check8(rd8, c0[15:8], "capture high");
    i_host.read_reg(8'hd8, rd8);
    check8(rd8, 8'h01, "rise flags");
    check8({7'h00, irq_out}, 8'h01, "irq module");
    module_line_in = 5'h00;
    repeat (8) @(negedge sys_clk_in);
    i_host.read_reg(8'hd8, rd8);
    check8(rd8, 8'h03, "fall flag");
    i_host.write_reg(8'hd8, 8'h02);
    repeat (3) @(negedge sys_clk_in);
    check8({7'h00, irq_out}, 8'h00, "irq disabled flag");
    i_host.read_reg(8'hd8, rd8);
    check8(rd8, 8'h02, "flag write");
    i_host.write_reg(8'hd8, 8'h00);
    i_host.write_reg(8'hda, 8'h00);
    i_host.write_reg(8'hdb, 8'h00);
    $display("test capture done");
    read_count(c0);
    d = c0 + 16'd3;
    i_host.write_reg(8'hec, d[7:0]);
    i_host.write_reg(8'hfc, d[15:8]);
    d = c0 + 16'd5;
    i_host.write_reg(8'hed, d[7:0]);
    i_host.write_reg(8'hfd, d[15:8]);
    i_host.write_reg(8'hdc, 8'h4c);
    i_host.write_reg(8'hdd, 8'h48);
    i_host.write_reg(8'hd8, 8'h40);
    repeat (6)
    begin
      timer0_ovf_in = 1'b1;
      @(negedge sys_clk_in);
      timer0_ovf_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
    end
    i_host.read_reg(8'hd8, rd8);
    check8(rd8, 8'h4c, "match flags");
    i_host.write_reg(8'hd8, 8'h00);
    check8({5'h00, module_line_oe_out[3:2], module_line_out[2]}, 8'h03, "toggle");
    i_host.write_reg(8'hdc, 8'h00);
    i_host.write_reg(8'hdd, 8'h00);
    $display("test match done");
    i_host.write_reg(8'hde, 8'h42);
    i_host.write_reg(8'hfe, 8'h80);
    i_host.write_reg(8'hee, 8'h80);
    timer0_ovf_in = 1'b1;
    i_host.write_reg(8'hd8, 8'h40);
    repeat (300) @(negedge sys_clk_in);
    ones = 0;
    repeat (512)
    begin
      @(negedge sys_clk_in);
      if (module_line_out[4] === 1'b1)
        ones++;
    end
    check_rng(16'(ones), 16'd254, 16'd258, "pwm half");
    check8({7'h00, module_line_oe_out[4]}, 8'h01, "pwm drive");
    // Duty changed through the high byte only
    i_host.write_reg(8'hfe, 8'h00);
    // New duty reaches the comparator only at a wrap, steady after the next
    repeat (600) @(negedge sys_clk_in);
    ones = 0;
    repeat (256)
    begin
      @(negedge sys_clk_in);
      if (module_line_out[4] === 1'b1)
        ones++;
    end
    check_rng(16'(ones), 16'd256, 16'd256, "pwm full");
    i_host.read_reg(8'hee, rd8);
    check8(rd8, 8'h00, "pwm reload");
    timer0_ovf_in = 1'b0;
    i_host.write_reg(8'hd8, 8'h00);
    $display("test pwm done");
    stop_test();
  end
endmodule // programmable_counter_array_tb
